// ### common/addr_unit_pkg.sv
// Constants and types shared by the program/data addressing core.
// Assumes a single 10 MHz ref_clk domain; every other file depends on it.
package addr_unit_pkg;

    // Program store geometry
    localparam int unsigned ROM_WORDS    = 1024;
    localparam int unsigned FC_W         = 10;
    localparam int unsigned PAGE_W       = 6;
    localparam int unsigned PAGE_COUNT   = 16;
    localparam int unsigned STACK_LEVELS = 3;

    // Data store geometry
    localparam int unsigned RAM_BITS     = 256;
    localparam int unsigned ROW_W        = 2;
    localparam int unsigned DIGIT_SEL_W  = 4;
    localparam int unsigned PTR_W        = 6;
    localparam int unsigned NIBBLE_W     = 4;
    localparam int unsigned LATCH_W      = 8;
    localparam int unsigned RAM_DIGITS   = 64;

    // Divider ratios and reset values
    localparam logic [4:0]      DIV_SLOW     = 5'h10;
    localparam logic [4:0]      DIV_FAST     = 5'h08;
    localparam logic [FC_W-1:0] FC_RESET     = 10'h000;
    localparam logic [FC_W-1:0] FC_STEP      = 10'h001;
    localparam logic [FC_W-1:0] ISR_VECTOR   = 10'h0FF;

    // Operations requested for one instruction cycle
    typedef enum logic [3:0] {
        OP_NEXT       = 4'h0,
        OP_JUMP       = 4'h1,
        OP_PAGE_JUMP  = 4'h2,
        OP_CALL       = 4'h3,
        OP_RETURN     = 4'h4,
        OP_INDIRECT   = 4'h5,
        OP_LOAD_PTR   = 4'h6,
        OP_DIGIT_TO_A = 4'h7,
        OP_A_TO_DIGIT = 4'h8,
        OP_EXCH_A     = 4'h9,
        OP_DIGIT_TO_Q = 4'hA,
        OP_Q_TO_DIGIT = 4'hB,
        OP_PORT_TO_DIG= 4'hC,
        OP_ROM_TO_Q   = 4'hD,
        OP_INTERRUPT  = 4'hE
    } op_t;

endpackage

// ### rtl/cycle_divider.sv
// Instruction-cycle enable generator.
// Assumes osc_edge is already synchronised to ref_clk.
`timescale 1ns/1ns
`default_nettype none
module cycle_divider
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_b,
    // Control
    input  wire logic osc_edge,
    input  wire logic div_by_8,
    // Result
    output logic      cycle_en
);

    typedef struct packed {
        logic [4:0] count;
        logic       en;
    } div_state_t;

    div_state_t s_q;
    div_state_t s_d;

    // Count oscillator edges, pulse once per selected ratio
    always_comb
    begin
        logic [4:0] ratio;
        ratio = div_by_8 ? addr_unit_pkg::DIV_FAST : addr_unit_pkg::DIV_SLOW;
        s_d = s_q;
        s_d.en = 1'b0;
        if (osc_edge)
        begin
            if (s_q.count >= ratio - 5'h01)
            begin
                s_d.count = 5'h00;
                s_d.en = 1'b1; // [RULE18]
            end
            else
            begin
                s_d.count = s_q.count + 5'h01;
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign cycle_en = s_q.en;

endmodule
`default_nettype wire

// ### rtl/addr_unit.sv
// Program fetch counter, return stack and data RAM addressing core.
// Assumes an external decoder supplies one operation per instruction cycle
// and a program store outside reads rom_addr.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// [RULE1] Addresses a read-only program store of 1,024 eight-bit words.
// [RULE2] Page-relative operations treat the store as 16 pages of 64 words.
// [RULE3] A 10-bit fetch counter selects exactly one program word.
// [RULE4] The fetch counter gets a new address every instruction cycle.
// [RULE5] Sequential count unless a transfer loads the target address.
// [RULE6] Three 10-bit return address registers give three nesting levels.
// [RULE7] Return registers act as LIFO: call pushes, return pops.
// [RULE8] Data RAM of 256 bits: 4 registers of 16 four-bit digits.
// [RULE9] Six-bit pointer; upper 2 bits pick the data register.
// [RULE10] Lower 4 pointer bits pick the digit in that register.
// [RULE11] Addressed digit loads to, from, or swaps with working nibble.
// [RULE12] Digit moves to or from output latch, and loads from I/O port.
// [RULE13] Direct load and exchange address RAM by 6-bit operand.
// [RULE14] Digit select field drives the four general output pins.
// [RULE15] All internal bits are positive logic.
// [RULE16] Output latch is 8 bits, fed by RAM, nibble or program constants.
// [RULE17] Pushing onto a full stack discards the bottom entry.
// [RULE18] Instruction cycle is the oscillator divided by 16 or 8.
// [RULE19] Return loads fetch counter from top and shifts others up.
module addr_unit
(
    // Clock and reset
    input  wire logic                                    ref_clk,
    input  wire logic                                    rst_b,
    // Oscillator and divider select
    input  wire logic                                    oscillator_input,
    input  wire logic                                    div_by_8,
    // Operation from the decoder
    input  wire addr_unit_pkg::op_t                      op,
    input  wire logic [addr_unit_pkg::FC_W-1:0]          target,
    input  wire logic [addr_unit_pkg::PTR_W-1:0]         operand,
    input  wire logic                                    use_operand,
    input  wire logic [addr_unit_pkg::LATCH_W-1:0]       rom_data,
    // Working nibble and I/O port from the datapath
    input  wire logic [addr_unit_pkg::NIBBLE_W-1:0]      nibble_in,
    input  wire logic [addr_unit_pkg::LATCH_W-1:0]       port_in,
    input  wire logic                                    port_high,
    // Program store side
    output logic [addr_unit_pkg::FC_W-1:0]               rom_addr,
    output logic                                         cycle_strobe,
    // Data side
    output logic [addr_unit_pkg::NIBBLE_W-1:0]           nibble_out,
    output logic                                         nibble_valid,
    output logic [addr_unit_pkg::LATCH_W-1:0]            latch_out,
    output logic [addr_unit_pkg::DIGIT_SEL_W-1:0]        gp_out,
    output logic [addr_unit_pkg::PTR_W-1:0]              ram_ptr
);

    ////////////////////////////////////////////////////////////////////////
    // Types and state

    typedef logic [addr_unit_pkg::FC_W-1:0] addr_t;

    typedef struct packed {
        logic [1:0]                               rst_sync;
        logic [1:0]                               osc_sync;
        logic                                     osc_prev;
        addr_t                                    fetch_counter;
        addr_t                                    stack_top;
        addr_t                                    stack_middle;
        addr_t                                    stack_bottom;
        logic [addr_unit_pkg::ROW_W-1:0]          register_row_select;
        logic [addr_unit_pkg::DIGIT_SEL_W-1:0]    digit_column_select;
        logic [addr_unit_pkg::NIBBLE_W-1:0]       nibble;
        logic                                     nibble_valid;
        logic [addr_unit_pkg::LATCH_W-1:0]        out_latch;
        logic [addr_unit_pkg::DIGIT_SEL_W-1:0]    gp;
        logic                                     strobe;
    } core_state_t;

    core_state_t s_q;
    core_state_t s_d;

    logic [addr_unit_pkg::NIBBLE_W-1:0] ram_q [addr_unit_pkg::RAM_DIGITS]; // [RULE8]
    logic                               ram_we;
    logic [addr_unit_pkg::PTR_W-1:0]    ram_idx;
    logic [addr_unit_pkg::NIBBLE_W-1:0] ram_wdata;
    logic [addr_unit_pkg::NIBBLE_W-1:0] digit;
    logic                               sys_rst_b;
    logic                               osc_edge;
    logic                               cycle_en;

    ////////////////////////////////////////////////////////////////////////
    // Reset release and oscillator synchroniser

    assign sys_rst_b = s_q.rst_sync[1];

    // Rising edge of the oscillator seen after two flops
    assign osc_edge = s_q.osc_sync[1] & ~s_q.osc_prev;

    cycle_divider u_div
    (
        .ref_clk  (ref_clk),
        .rst_b    (sys_rst_b),
        .osc_edge (osc_edge),
        .div_by_8 (div_by_8),
        .cycle_en (cycle_en)
    );

    ////////////////////////////////////////////////////////////////////////
    // RAM addressing

    // Direct forms use the operand, others the pointer
    assign ram_idx = use_operand ? operand                                   // [RULE13]
                   : {s_q.register_row_select, s_q.digit_column_select};     // [RULE9] [RULE10]
    assign digit   = ram_q[ram_idx];

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic; synchronisers update every clock, operations once per instruction cycle

    always_comb
    begin
        addr_t seq;
        seq          = addr_t'(s_q.fetch_counter + addr_unit_pkg::FC_STEP); // [RULE5]
        s_d          = s_q;
        s_d.rst_sync = {s_q.rst_sync[0], 1'b1}; // Reset release pipeline, two flops
        s_d.osc_sync = {s_q.osc_sync[0], oscillator_input};
        s_d.osc_prev = s_q.osc_sync[1];
        s_d.strobe   = cycle_en;
        ram_we       = 1'b0;
        ram_wdata    = nibble_in;
        if (cycle_en) // [RULE18]
        begin
            s_d.fetch_counter = seq; // [RULE4]
            s_d.nibble_valid  = 1'b0;
            case (op)
                addr_unit_pkg::OP_JUMP, addr_unit_pkg::OP_INDIRECT:
                begin
                    s_d.fetch_counter = target; // [RULE5] [RULE3]
                end
                addr_unit_pkg::OP_PAGE_JUMP:
                begin
                    // Keep page bits, replace word-in-page bits
                    s_d.fetch_counter = {s_q.fetch_counter[addr_unit_pkg::FC_W-1:addr_unit_pkg::PAGE_W],
                                         target[addr_unit_pkg::PAGE_W-1:0]}; // [RULE2]
                end
                addr_unit_pkg::OP_CALL, addr_unit_pkg::OP_INTERRUPT:
                begin
                    s_d.stack_top     = seq;               // [RULE7]
                    s_d.stack_middle  = s_q.stack_top;     // [RULE6]
                    s_d.stack_bottom  = s_q.stack_middle;  // [RULE17]
                    s_d.fetch_counter = (op == addr_unit_pkg::OP_INTERRUPT)
                                        ? addr_unit_pkg::ISR_VECTOR : target;
                end
                addr_unit_pkg::OP_RETURN:
                begin
                    s_d.fetch_counter = s_q.stack_top;     // [RULE19] [RULE7]
                    s_d.stack_top     = s_q.stack_middle;
                    s_d.stack_middle  = s_q.stack_bottom;
                end
                addr_unit_pkg::OP_LOAD_PTR:
                begin
                    {s_d.register_row_select, s_d.digit_column_select} = operand; // [RULE9]
                end
                addr_unit_pkg::OP_DIGIT_TO_A:
                begin
                    s_d.nibble       = digit; // [RULE11]
                    s_d.nibble_valid = 1'b1;
                end
                addr_unit_pkg::OP_A_TO_DIGIT:
                begin
                    ram_we = 1'b1; // [RULE11]
                end
                addr_unit_pkg::OP_EXCH_A:
                begin
                    ram_we           = 1'b1; // [RULE11]
                    s_d.nibble       = digit;
                    s_d.nibble_valid = 1'b1;
                end
                addr_unit_pkg::OP_DIGIT_TO_Q:
                begin
                    // Digit fills the lower half, nibble the upper half
                    s_d.out_latch = {nibble_in, digit}; // [RULE12] [RULE16]
                end
                addr_unit_pkg::OP_Q_TO_DIGIT:
                begin
                    ram_we    = 1'b1; // [RULE12]
                    ram_wdata = s_q.out_latch[addr_unit_pkg::NIBBLE_W-1:0];
                    s_d.nibble = s_q.out_latch[addr_unit_pkg::LATCH_W-1:addr_unit_pkg::NIBBLE_W];
                    s_d.nibble_valid = 1'b1;
                end
                addr_unit_pkg::OP_PORT_TO_DIG:
                begin
                    ram_we    = 1'b1; // [RULE12]
                    ram_wdata = port_high ? port_in[addr_unit_pkg::LATCH_W-1:addr_unit_pkg::NIBBLE_W]
                                          : port_in[addr_unit_pkg::NIBBLE_W-1:0];
                end
                addr_unit_pkg::OP_ROM_TO_Q:
                begin
                    s_d.out_latch = rom_data; // [RULE16]
                end
                default:
                begin
                    s_d.fetch_counter = seq;
                end
            endcase
        end
        s_d.gp = s_d.digit_column_select; // [RULE14]
        // Hold the core at its reset values until the released copy rises
        if (!sys_rst_b)
        begin
            s_d          = s_q;
            s_d.rst_sync = {s_q.rst_sync[0], 1'b1};
            ram_we       = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    // Whole state; the pin reset clears it, the released copy gates it above
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q.rst_sync            <= 2'h0;
            s_q.osc_sync            <= 2'h0;
            s_q.osc_prev            <= 1'b0;
            s_q.fetch_counter       <= addr_unit_pkg::FC_RESET;
            s_q.stack_top           <= addr_unit_pkg::FC_RESET;
            s_q.stack_middle        <= addr_unit_pkg::FC_RESET;
            s_q.stack_bottom        <= addr_unit_pkg::FC_RESET;
            s_q.register_row_select <= 2'h0;
            s_q.digit_column_select <= 4'h0;
            s_q.nibble              <= 4'h0;
            s_q.nibble_valid        <= 1'b0;
            s_q.out_latch           <= 8'h00;
            s_q.gp                  <= 4'h0;
            s_q.strobe              <= 1'b0;
        end
        else
        begin
            s_q.rst_sync            <= s_d.rst_sync;
            s_q.osc_sync            <= s_d.osc_sync;
            s_q.osc_prev            <= s_d.osc_prev;
            s_q.fetch_counter       <= s_d.fetch_counter;
            s_q.stack_top           <= s_d.stack_top;
            s_q.stack_middle        <= s_d.stack_middle;
            s_q.stack_bottom        <= s_d.stack_bottom;
            s_q.register_row_select <= s_d.register_row_select;
            s_q.digit_column_select <= s_d.digit_column_select;
            s_q.nibble              <= s_d.nibble;
            s_q.nibble_valid        <= s_d.nibble_valid;
            s_q.out_latch           <= s_d.out_latch;
            s_q.gp                  <= s_d.gp;
            s_q.strobe              <= s_d.strobe;
        end
    end

    // Data RAM write port; contents are undefined after power-up
    always_ff @(posedge ref_clk)
    begin
        if (ram_we)
        begin
            ram_q[ram_idx] <= ram_wdata; // [RULE15]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all from flops

    assign rom_addr     = s_q.fetch_counter; // [RULE1]
    assign cycle_strobe = s_q.strobe;
    assign nibble_out   = s_q.nibble;
    assign nibble_valid = s_q.nibble_valid;
    assign latch_out    = s_q.out_latch;
    assign gp_out       = s_q.gp;
    assign ram_ptr      = {s_q.register_row_select, s_q.digit_column_select};

endmodule
`default_nettype wire

// ### bench/addr_unit_asserts.sv
// Checker for the addressing core, bound to its top module.
// Assumes the single ref_clk domain and the active-low rst_b port.
`timescale 1ns/1ns
`default_nettype none
module addr_unit_asserts
(
    // Clock and reset
    input wire logic               ref_clk,
    input wire logic               rst_b,
    // Watched inputs
    input wire logic               oscillator_input,
    input wire logic               div_by_8,
    input wire addr_unit_pkg::op_t op,
    input wire logic [9:0]         target,
    input wire logic [5:0]         operand,
    // Watched outputs
    input wire logic [9:0]         rom_addr,
    input wire logic               cycle_strobe,
    input wire logic [3:0]         gp_out,
    input wire logic [5:0]         ram_ptr
);
    // Copies from the last clock and the oscillator rise count
    typedef struct packed {
        addr_unit_pkg::op_t op;
        logic [9:0]         pc;
        logic [9:0]         tgt;
        logic [5:0]         ptr;
        logic [5:0]         opnd;
        logic               osc;
        logic [5:0]         rises;
        logic               seen;
    } watch_t;
    watch_t q;
    watch_t d;
    logic   rise;

    assign rise = oscillator_input & ~q.osc;

    // Next watch state; the count restarts at each strobe
    always_comb
    begin
        d = q;
        d.op = op;
        d.pc = rom_addr;
        d.tgt = target;
        d.ptr = ram_ptr;
        d.opnd = operand;
        d.osc = oscillator_input;
        d.rises = cycle_strobe ? 6'h00 : 6'(q.rises + 6'(rise));
        d.seen = q.seen | cycle_strobe;
    end

    // Watch state register
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            q <= '0;
        else
            q <= d;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////////////////////////////////////////
    a_strobe_single: assert property (cycle_strobe |=> !cycle_strobe)
        else $error("cycle strobe held past one clock");
    a_hold_between: assert property (!cycle_strobe |-> rom_addr == q.pc && ram_ptr == q.ptr)
        else $error("state moved outside an instruction cycle edge");
    a_gp_follows: assert property (gp_out == ram_ptr[3:0])
        else $error("general outputs differ from digit select field");
    a_pc_step: assert property (cycle_strobe && q.op == addr_unit_pkg::OP_NEXT
        |-> rom_addr == 10'(q.pc + 10'h001))
        else $error("fetch counter did not count up by one");
    a_jump_load: assert property (cycle_strobe && q.op == addr_unit_pkg::OP_JUMP
        |-> rom_addr == q.tgt)
        else $error("jump did not load the target");
    a_page_keep: assert property (cycle_strobe && q.op == addr_unit_pkg::OP_PAGE_JUMP
        |-> rom_addr == {q.pc[9:6], q.tgt[5:0]})
        else $error("page jump left its page");
    a_call_target: assert property (cycle_strobe && q.op == addr_unit_pkg::OP_CALL
        |-> rom_addr == q.tgt)
        else $error("call did not load the target");
    a_irq_vector: assert property (cycle_strobe && q.op == addr_unit_pkg::OP_INTERRUPT
        |-> rom_addr == addr_unit_pkg::ISR_VECTOR)
        else $error("interrupt did not reach its vector");
    a_ptr_load: assert property (cycle_strobe && q.op == addr_unit_pkg::OP_LOAD_PTR
        |-> ram_ptr == q.opnd)
        else $error("pointer load lost its operand");
    a_cycle_len: assert property (cycle_strobe && q.seen
        |-> 6'(q.rises + 6'(rise)) == (div_by_8 ? 6'h08 : 6'h10))
        else $error("instruction cycle length wrong");
endmodule
bind addr_unit addr_unit_asserts i_asserts (.ref_clk(ref_clk), .rst_b(rst_b),
    .oscillator_input(oscillator_input), .div_by_8(div_by_8), .op(op), .target(target),
    .operand(operand), .rom_addr(rom_addr), .cycle_strobe(cycle_strobe), .gp_out(gp_out),
    .ram_ptr(ram_ptr));
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench for the addressing core, one task per scenario.
// Assumes the checker is bound from its own file; inputs move on falling edges.
`timescale 1ns/1ns
`default_nettype none
module tb;
    // Clock, reset and oscillator
    logic               ref_clk = 1'b0;
    logic               rst_b = 1'b0;
    logic [1:0]         osc_cnt = 2'h0;
    logic               div_by_8 = 1'b0;
    // Decoder and datapath side
    addr_unit_pkg::op_t op = addr_unit_pkg::OP_NEXT;
    logic [9:0]         target = 10'h000;
    logic [5:0]         operand = 6'h00;
    logic               use_operand = 1'b0;
    logic [7:0]         rom_data = 8'h00;
    logic [3:0]         nibble_in = 4'h0;
    logic [7:0]         port_in = 8'h00;
    logic               port_high = 1'b0;
    // Outputs
    logic [9:0]         rom_addr;
    logic               cycle_strobe;
    logic [3:0]         nibble_out;
    logic               nibble_valid;
    logic [7:0]         latch_out;
    logic [3:0]         gp_out;
    logic [5:0]         ram_ptr;
    // Expected fetch counter, return stack and bookkeeping
    logic [9:0]         pc = 10'h000;
    logic [2:0][9:0]    stk = '0;
    int                 gap = 0;
    int                 errors = 0;
    int                 comparisons = 0;

    // Clock and an oscillator with a rise every 4 clocks
    always #50 ref_clk = ~ref_clk;
    always @(negedge ref_clk) osc_cnt <= osc_cnt + 2'h1;

    addr_unit i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .oscillator_input(osc_cnt[1]),
        .div_by_8(div_by_8), .op(op), .target(target), .operand(operand),
        .use_operand(use_operand), .rom_data(rom_data), .nibble_in(nibble_in),
        .port_in(port_in), .port_high(port_high), .rom_addr(rom_addr),
        .cycle_strobe(cycle_strobe), .nibble_out(nibble_out), .nibble_valid(nibble_valid),
        .latch_out(latch_out), .gp_out(gp_out), .ram_ptr(ram_ptr));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // One instruction cycle: hold the op until its strobe, then judge the counter
    task automatic step(input addr_unit_pkg::op_t o, input logic [9:0] t = 10'h000,
                        input logic [5:0] d = 6'h00, input logic u = 1'b0);
        int n;
        n = 0;
        op = o;
        target = t;
        operand = d;
        use_operand = u;
        do
        begin
            @(negedge ref_clk);
            n++;
        end
        while (cycle_strobe !== 1'b1 && n < 200);
        gap = n;
        case (o)
            addr_unit_pkg::OP_JUMP, addr_unit_pkg::OP_INDIRECT: pc = t;
            addr_unit_pkg::OP_PAGE_JUMP: pc = {pc[9:6], t[5:0]};
            addr_unit_pkg::OP_CALL, addr_unit_pkg::OP_INTERRUPT:
            begin
                stk = {stk[1], stk[0], 10'(pc + 10'h001)};
                pc = (o == addr_unit_pkg::OP_CALL) ? t : addr_unit_pkg::ISR_VECTOR;
            end
            addr_unit_pkg::OP_RETURN:
            begin
                pc = stk[0];
                stk = {stk[2], stk[2], stk[1]};
            end
            default: pc = pc + 10'h001;
        endcase
        check("cycle_strobe", 10'(cycle_strobe), 10'h001);
        check("rom_addr", rom_addr, pc);
    endtask

    task automatic do_reset(input logic div);
        @(negedge ref_clk);
        rst_b = 1'b0;
        div_by_8 = div;
        op = addr_unit_pkg::OP_NEXT;
        repeat (2) @(negedge ref_clk);
        check("latch_out", 10'(latch_out), 10'h000);
        check("rom_addr", rom_addr, 10'h000);
        rst_b = 1'b1;
        pc = 10'h000;
        stk = '0;
    endtask

    // Counting, cycle length and wrap of the counter
    task automatic t_sequence();
        step(addr_unit_pkg::OP_NEXT);
        step(addr_unit_pkg::OP_NEXT);
        check("gap", 10'(gap), 10'h040);
        step(addr_unit_pkg::OP_JUMP, 10'h3FE);
        repeat (2) step(addr_unit_pkg::OP_NEXT);
        check("rom_addr", rom_addr, 10'h000);
    endtask

    // Four calls overflow the three levels, then four returns
    task automatic t_stack();
        step(addr_unit_pkg::OP_JUMP, 10'h100);
        step(addr_unit_pkg::OP_CALL, 10'h200);
        step(addr_unit_pkg::OP_CALL, 10'h300);
        step(addr_unit_pkg::OP_CALL, 10'h040);
        step(addr_unit_pkg::OP_CALL, 10'h050);
        repeat (4) step(addr_unit_pkg::OP_RETURN);
        check("rom_addr", rom_addr, 10'h201);
    endtask

    // Page-relative jump, then interrupt push and return
    task automatic t_page();
        step(addr_unit_pkg::OP_JUMP, 10'h2C5);
        step(addr_unit_pkg::OP_PAGE_JUMP, 10'h015);
        check("rom_addr", rom_addr, 10'h2D5);
        step(addr_unit_pkg::OP_INTERRUPT);
        step(addr_unit_pkg::OP_RETURN);
        check("rom_addr", rom_addr, 10'h2D6);
        step(addr_unit_pkg::OP_INDIRECT, 10'h123);
        check("rom_addr", rom_addr, 10'h123);
    endtask

    // Pointer fields, nibble moves and direct addressing
    task automatic t_ram();
        nibble_in = 4'hA;
        step(addr_unit_pkg::OP_LOAD_PTR, 10'h000, 6'h25);
        check("ram_ptr", 10'(ram_ptr), 10'h025);
        check("gp_out", 10'(gp_out), 10'h005);
        step(addr_unit_pkg::OP_A_TO_DIGIT);
        step(addr_unit_pkg::OP_LOAD_PTR, 10'h000, 6'h05);
        nibble_in = 4'h3;
        step(addr_unit_pkg::OP_A_TO_DIGIT);
        step(addr_unit_pkg::OP_LOAD_PTR, 10'h000, 6'h25);
        step(addr_unit_pkg::OP_DIGIT_TO_A);
        check("nibble_out", 10'(nibble_out), 10'h00A);
        check("nibble_valid", 10'(nibble_valid), 10'h001);
        nibble_in = 4'h6;
        step(addr_unit_pkg::OP_EXCH_A);
        check("nibble_out", 10'(nibble_out), 10'h00A);
        step(addr_unit_pkg::OP_DIGIT_TO_A);
        check("nibble_out", 10'(nibble_out), 10'h006);
        step(addr_unit_pkg::OP_DIGIT_TO_A, 10'h000, 6'h05, 1'b1);
        check("nibble_out", 10'(nibble_out), 10'h003);
        nibble_in = 4'h7;
        step(addr_unit_pkg::OP_A_TO_DIGIT, 10'h000, 6'h3A, 1'b1);
        check("nibble_valid", 10'(nibble_valid), 10'h000);
        step(addr_unit_pkg::OP_LOAD_PTR, 10'h000, 6'h3A);
        step(addr_unit_pkg::OP_DIGIT_TO_A);
        check("nibble_out", 10'(nibble_out), 10'h007);
    endtask

    // Output latch moves and port loads into the digit at 0x3A
    task automatic t_latch();
        nibble_in = 4'h9;
        step(addr_unit_pkg::OP_DIGIT_TO_Q);
        check("latch_out", 10'(latch_out), 10'h097);
        rom_data = 8'hC3;
        step(addr_unit_pkg::OP_ROM_TO_Q);
        check("latch_out", 10'(latch_out), 10'h0C3);
        step(addr_unit_pkg::OP_Q_TO_DIGIT);
        check("nibble_out", 10'(nibble_out), 10'h00C);
        step(addr_unit_pkg::OP_DIGIT_TO_A);
        check("nibble_out", 10'(nibble_out), 10'h003);
        port_in = 8'h5E;
        port_high = 1'b1;
        step(addr_unit_pkg::OP_PORT_TO_DIG);
        step(addr_unit_pkg::OP_DIGIT_TO_A);
        check("nibble_out", 10'(nibble_out), 10'h005);
        port_high = 1'b0;
        step(addr_unit_pkg::OP_PORT_TO_DIG);
        step(addr_unit_pkg::OP_DIGIT_TO_A);
        check("nibble_out", 10'(nibble_out), 10'h00E);
    endtask

    // Reset in mid-run into the divide-by-8 ratio
    task automatic t_fast();
        do_reset(1'b1);
        repeat (3) step(addr_unit_pkg::OP_NEXT);
        check("gap", 10'(gap), 10'h020);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        do_reset(1'b0);
        t_sequence();
        t_stack();
        t_page();
        t_ram();
        t_latch();
        t_fast();
        give_verdict();
    end

    // Watchdog well beyond the expected 2,600 or so clocks
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
